// ---- common/pin_remap_pkg.sv ----
// constants, types and pin tables for the remappable input selector block
package pin_remap_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_GROUPS      = 4;
    localparam int NUM_CODES       = 15;
    localparam int NUM_PORT_A_PADS = 15;
    localparam int NUM_PORT_B_PADS = 14;
    localparam int NUM_PADS        = NUM_PORT_A_PADS + NUM_PORT_B_PADS;
    localparam int NUM_SELECTORS   = 47;
    localparam int ADDR_WIDTH      = 12;
    localparam int DATA_WIDTH      = 32;

    typedef logic [3:0] selector_type;
    typedef logic [4:0] pad_index_type;
    typedef logic [1:0] lock_key_type;

    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] CONFIG_CONTROL_0_ADDR = 12'h000;
    localparam logic [3:0]  SELECTOR_PAGE         = 4'h1;   // selector i at 0x100 + 4*i
    localparam int          LOCK_BIT              = 13;     // config write lock
    localparam int          LOCK_KEY_LSB          = 0;      // lock key field 1:0
    localparam selector_type SELECTOR_OFF         = 4'h0;
    localparam selector_type SELECTOR_RESET       = 4'h0;
    localparam logic        LOCK_RESET            = 1'b0;
    localparam lock_key_type LOCK_KEY_OPEN        = 2'h0;   // lock bit may change
    localparam lock_key_type LOCK_KEY_GUARD       = 2'h1;   // lock bit frozen
    localparam lock_key_type LOCK_KEY_SEAL        = 2'h3;   // frozen until reset
    localparam lock_key_type LOCK_KEY_RESET       = 2'h1;
    localparam logic [1:0]  RESP_OKAY             = 2'h0;
    localparam logic [1:0]  RESP_SLVERR           = 2'h2;

    // ------------------------------------------------------------------
    // peripheral input slots, grouped; first slot of each group
    // ------------------------------------------------------------------
    localparam int GROUP_FIRST [NUM_GROUPS] = '{0, 14, 26, 37};
    localparam int EXT_IRQ_0_IDX = 0;
    localparam int EXT_IRQ_1_IDX = 14;
    localparam int EXT_IRQ_2_IDX = 26;
    localparam int EXT_IRQ_3_IDX = 37;
    localparam int NMI_IDX       = 38;

    // group of a peripheral input slot
    function automatic int groupOf(input int slot);
        int g;
        g = 0;
        for (int k = 1; k < NUM_GROUPS; k++) begin
            if (slot >= GROUP_FIRST[k]) begin
                g = k;
            end
        end
        return g;
    endfunction : groupOf

    // pad numbering: port A pin n is n, port B pin n is 15 + n
    function automatic pad_index_type padA(input int n);
        return pad_index_type'(n);
    endfunction : padA

    function automatic pad_index_type padB(input int n);
        return pad_index_type'(NUM_PORT_A_PADS + n);
    endfunction : padB

    // pads reached by codes 1..15 of each group, code 1 first
    localparam pad_index_type GROUP_PADS [NUM_GROUPS][NUM_CODES] = '{
        '{padA(3), padA(7), padA(11), padB(0), padB(4), padB(8), padB(12),
          padA(2), padA(6), padA(10), padA(14), padB(3), padB(7), padB(11), padA(9)},
        '{padA(4), padA(8), padA(12), padB(1), padB(5), padB(9), padB(13),
          padA(3), padA(7), padA(11), padB(0), padB(4), padB(8), padB(12), padA(0)},
        '{padA(5), padA(9), padA(13), padB(2), padB(6), padB(10), padA(0),
          padA(4), padA(8), padA(12), padB(1), padB(5), padB(9), padB(13), padA(1)},
        '{padA(6), padA(10), padA(14), padB(3), padB(7), padB(11), padA(1),
          padA(5), padA(9), padA(13), padB(2), padB(6), padB(10), padA(8), padA(2)}
    };

endpackage : pin_remap_pkg

// ---- hdl/input_pin_mux.sv ----
// one peripheral input: picks one pad of its group by a 4-bit code
`timescale 1ns/1ps
`default_nettype none

module input_pin_mux
    import pin_remap_pkg::*;
#(
    parameter int GROUP = 0
) (
    // selection
    input  wire selector_type          selector,
    // pads
    input  wire logic [NUM_PADS-1:0]   pads,
    // peripheral side
    output logic                       periphIn
);

    // ------------------------------------------------------------------
    // pad multiplexer
    // ------------------------------------------------------------------
    // code zero drives a quiet low; other codes index this group's list only
    // code zero off
    always_comb begin
        periphIn = 1'b0;
        if (selector != SELECTOR_OFF) begin
            periphIn = pads[GROUP_PADS[GROUP][int'(selector) - 1]];
        end
    end

endmodule : input_pin_mux

`default_nettype wire

// ---- hdl/remappable_input_select.sv ----
// remappable input selector fabric with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module remappable_input_select
    import pin_remap_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // axi4-lite write address
    input  wire logic [ADDR_WIDTH-1:0]      awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    // axi4-lite write data
    input  wire logic [DATA_WIDTH-1:0]      wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // axi4-lite write response
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // axi4-lite read address
    input  wire logic [ADDR_WIDTH-1:0]      araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    // axi4-lite read data
    output logic [DATA_WIDTH-1:0]           rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // device pads
    input  wire logic [NUM_PORT_A_PADS-1:0] portAPads,
    input  wire logic [NUM_PORT_B_PADS-1:0] portBPads,
    // peripheral inputs and lock state
    output logic [NUM_SELECTORS-1:0]        peripheralInputs,
    output logic                            configWriteLock
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    selector_type              sel [NUM_SELECTORS];
    selector_type              next_sel [NUM_SELECTORS];
    lock_key_type              lockKey;
    lock_key_type              next_lockKey;
    logic                      next_configWriteLock;
    logic                      awHeld;
    logic                      next_awHeld;
    logic                      wHeld;
    logic                      next_wHeld;
    logic [ADDR_WIDTH-1:0]     awAddrHeld;
    logic [ADDR_WIDTH-1:0]     next_awAddrHeld;
    logic [DATA_WIDTH-1:0]     wDataHeld;
    logic [DATA_WIDTH-1:0]     next_wDataHeld;
    logic [3:0]                wStrbHeld;
    logic [3:0]                next_wStrbHeld;
    logic                      next_awready;
    logic                      next_wready;
    logic                      next_bvalid;
    logic [1:0]                next_bresp;
    logic                      next_arready;
    logic                      next_rvalid;
    logic [1:0]                next_rresp;
    logic [DATA_WIDTH-1:0]     next_rdata;
    logic [NUM_PADS-1:0]       pads;
    logic                      wrCommit;
    logic                      wrIsConfig;
    logic                      wrIsSelector;
    logic [5:0]                wrIndex;
    logic                      rdIsConfig;
    logic                      rdIsSelector;
    logic [5:0]                rdIndex;

    assign pads = {portBPads, portAPads};

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // selector i answers at 0x100 + 4*i; everything else but config is unmapped
    assign wrCommit     = awHeld && wHeld && !bvalid;
    assign wrIndex      = awAddrHeld[7:2];
    assign wrIsConfig   = awAddrHeld[11:2] == CONFIG_CONTROL_0_ADDR[11:2];
    assign wrIsSelector = awAddrHeld[11:8] == SELECTOR_PAGE
                          && wrIndex < 6'(NUM_SELECTORS);
    assign rdIndex      = araddr[7:2];
    assign rdIsConfig   = araddr[11:2] == CONFIG_CONTROL_0_ADDR[11:2];
    assign rdIsSelector = araddr[11:8] == SELECTOR_PAGE
                          && rdIndex < 6'(NUM_SELECTORS);

    // ------------------------------------------------------------------
    // write channel and register updates
    // ------------------------------------------------------------------
    // address and data are caught in either order, committed once both held
    always_comb begin
        next_awHeld          = awHeld;
        next_wHeld           = wHeld;
        next_awAddrHeld      = awAddrHeld;
        next_wDataHeld       = wDataHeld;
        next_wStrbHeld       = wStrbHeld;
        next_bvalid          = bvalid;
        next_bresp           = bresp;
        next_lockKey         = lockKey;
        next_configWriteLock = configWriteLock;
        for (int i = 0; i < NUM_SELECTORS; i++) begin
            next_sel[i] = sel[i];
        end
        if (awvalid && awready) begin
            next_awHeld     = 1'b1;
            next_awAddrHeld = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld     = 1'b1;
            next_wDataHeld = wdata;
            next_wStrbHeld = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wrCommit) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = (wrIsConfig || wrIsSelector) ? RESP_OKAY : RESP_SLVERR;
            if (wrIsConfig) begin
                // a sealed key stays sealed until the next reset
                if (wStrbHeld[0] && lockKey != LOCK_KEY_SEAL) begin
                    next_lockKey = wDataHeld[LOCK_KEY_LSB +: 2];
                end
                if (wStrbHeld[1] && lockKey == LOCK_KEY_OPEN) begin
                    next_configWriteLock = wDataHeld[LOCK_BIT];
                end
            end
            if (wrIsSelector && wStrbHeld[0] && !configWriteLock) begin
                next_sel[wrIndex] = wDataHeld[3:0];
            end
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready  = !next_wHeld && !next_bvalid;
    end

    // register write side; reset clears every selector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld          <= 1'b0;
            wHeld           <= 1'b0;
            awAddrHeld      <= '0;
            wDataHeld       <= '0;
            wStrbHeld       <= 4'h0;
            awready         <= 1'b0;
            wready          <= 1'b0;
            bvalid          <= 1'b0;
            bresp           <= RESP_OKAY;
            lockKey         <= LOCK_KEY_RESET;
            configWriteLock <= LOCK_RESET;
            for (int i = 0; i < NUM_SELECTORS; i++) begin
                sel[i] <= SELECTOR_RESET;
            end
        end else begin
            awHeld          <= next_awHeld;
            wHeld           <= next_wHeld;
            awAddrHeld      <= next_awAddrHeld;
            wDataHeld       <= next_wDataHeld;
            wStrbHeld       <= next_wStrbHeld;
            awready         <= next_awready;
            wready          <= next_wready;
            bvalid          <= next_bvalid;
            bresp           <= next_bresp;
            lockKey         <= next_lockKey;
            configWriteLock <= next_configWriteLock;
            for (int i = 0; i < NUM_SELECTORS; i++) begin
                sel[i] <= next_sel[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    // one read at a time; data shows live selectors and lock state
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = '0;
            next_rresp  = RESP_OKAY;
            if (rdIsConfig) begin
                next_rdata[LOCK_BIT]          = configWriteLock;
                next_rdata[LOCK_KEY_LSB +: 2] = lockKey;
            end else if (rdIsSelector) begin
                next_rdata[3:0] = sel[rdIndex];
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    // register read side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // ------------------------------------------------------------------
    // peripheral input multiplexers
    // ------------------------------------------------------------------
    // inputs only, no pad drive
    for (genvar s = 0; s < NUM_SELECTORS; s++) begin : gen_mux
        input_pin_mux #(
            .GROUP    (groupOf(s))
        ) u_mux (
            .selector (sel[s]),
            .pads     (pads),
            .periphIn (peripheralInputs[s])
        );
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic firstCycle;
    logic anySelSet;

    // marks the first cycle after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            firstCycle <= 1'b1;
        end else begin
            firstCycle <= 1'b0;
        end
    end

    // any selector holding a non-zero code
    always_comb begin
        anySelSet = 1'b0;
        for (int i = 0; i < NUM_SELECTORS; i++) begin
            anySelSet = anySelSet | (sel[i] != SELECTOR_OFF);
        end
    end

    sequence s_bothTaken;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_selWriteOpen;
        wrCommit && wrIsSelector && wStrbHeld[0] && !configWriteLock;
    endsequence

    property p_off_low;
        @(posedge clk) disable iff (!reset_n)
        sel[EXT_IRQ_3_IDX] == SELECTOR_OFF |-> !peripheralInputs[EXT_IRQ_3_IDX];
    endproperty
    a_off_low: assert property (p_off_low) else $error("unselected input not low");

    property p_irq0_portb0;
        @(posedge clk) disable iff (!reset_n)
        sel[EXT_IRQ_0_IDX] == 4'h4 |-> peripheralInputs[EXT_IRQ_0_IDX] == portBPads[0];
    endproperty
    a_irq0_portb0: assert property (p_irq0_portb0) else $error("irq0 code 4 not pin B0");

    property p_nmi_last_code;
        @(posedge clk) disable iff (!reset_n)
        sel[NMI_IDX] == 4'hF |-> peripheralInputs[NMI_IDX] == portAPads[2];
    endproperty
    a_nmi_last_code: assert property (p_nmi_last_code) else $error("nmi code 15 not pin A2");

    property p_irq1_code15;
        @(posedge clk) disable iff (!reset_n)
        sel[EXT_IRQ_1_IDX] == 4'hF |-> peripheralInputs[EXT_IRQ_1_IDX] == portAPads[0];
    endproperty
    a_irq1_code15: assert property (p_irq1_code15) else $error("irq1 code 15 not pin A0");

    property p_reset_defaults;
        @(posedge clk) disable iff (!reset_n)
        firstCycle |-> !anySelSet && !configWriteLock && peripheralInputs == '0;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset left a mapping");

    property p_locked_ignored;
        @(posedge clk) disable iff (!reset_n)
        wrCommit && wrIsSelector && configWriteLock |=> sel[$past(wrIndex)] == $past(sel[wrIndex]);
    endproperty
    a_locked_ignored: assert property (p_locked_ignored) else $error("locked write landed");

    property p_open_write;
        @(posedge clk) disable iff (!reset_n)
        s_selWriteOpen |=> sel[$past(wrIndex)] == $past(wDataHeld[3:0]) && bvalid;
    endproperty
    a_open_write: assert property (p_open_write) else $error("open write not stored");

    property p_lock_needs_key;
        @(posedge clk) disable iff (!reset_n)
        !$stable(configWriteLock) |-> $past(lockKey) == LOCK_KEY_OPEN;
    endproperty
    a_lock_needs_key: assert property (p_lock_needs_key) else $error("lock moved while keyed");

    property p_write_response;
        @(posedge clk) disable iff (!reset_n)
        s_bothTaken |-> !bvalid ##1 !bvalid ##1 bvalid;
    endproperty
    a_write_response: assert property (p_write_response) else $error("write answer late");

    property p_read_response;
        @(posedge clk) disable iff (!reset_n)
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_read_response: assert property (p_read_response) else $error("read answer late");

endmodule : remappable_input_select

`default_nettype wire

// ---- test/pad_source_model.sv ----
// pad source model standing at the far side of the selector fabric
`timescale 1ns/1ps
`default_nettype none

module pad_source_model (
    // clock
    input  wire logic        clk,
    // pattern control: one pad high, or with invert all but that pad
    input  wire logic [4:0]  padSel,
    input  wire logic        invert,
    // pads, port A pins in bits 0..14, port B pins above them
    output logic [14:0]      portAPads,
    output logic [13:0]      portBPads
);
    // pads as inputs
    // pads are only ever driven toward the block, never read back
    always_ff @(posedge clk) begin
        {portBPads, portAPads} <= {29{invert}} ^ (29'h0000_0001 << padSel);
    end
endmodule : pad_source_model

`default_nettype wire

// ---- test/tb_remappable_input_select.sv ----
// self-checking bench for the remappable input selector fabric
`timescale 1ns/1ps
`default_nettype none

module tb_remappable_input_select;
    import pin_remap_pkg::*;

    logic                    clk, reset_n, awvalid, awready, wvalid, wready;
    logic                    bvalid, bready, arvalid, arready, rvalid, rready, invert;
    logic [11:0]             awaddr, araddr;
    logic [31:0]             wdata, rdata;
    logic [3:0]              wstrb;
    logic [1:0]              bresp, rresp;
    logic [14:0]             portAPads;
    logic [13:0]             portBPads;
    logic [NUM_SELECTORS-1:0] peripheralInputs;
    logic                    configWriteLock;
    logic [4:0]              padSel;
    int                      badCount, compares, cycles;
    // rows: slot, code, pad (port A pin n is n, port B pin n is 15 + n)
    int rows [11][3] = '{'{0, 4, 15}, '{0, 15, 9}, '{13, 1, 3}, '{14, 7, 28}, '{14, 15, 0},
        '{25, 15, 0}, '{26, 7, 0}, '{36, 15, 1}, '{37, 14, 8}, '{38, 15, 2}, '{46, 1, 6}};

    remappable_input_select u_dut (.clk(clk), .reset_n(reset_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .portAPads(portAPads), .portBPads(portBPads),
        .peripheralInputs(peripheralInputs), .configWriteLock(configWriteLock));

    pad_source_model u_pads (.clk(clk), .padSel(padSel), .invert(invert),
        .portAPads(portAPads), .portBPads(portBPads));

    // ------------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // cut a hang short well beyond the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            giveVerdict();
        end
    end

    task automatic giveVerdict();
        $display("compares=%0d badCount=%0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [11:0] selAddr(input int slot);
        return 12'(12'h100 + 4 * slot);
    endfunction : selAddr

    // write with address and data offered together, released as each is taken
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : axiWr

    task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axiRd

    // the model latches and drives the pads on the first edge; outputs looked at 5 ns after the second edge
    task automatic setPads(input int sel, input logic inv);
        padSel <= 5'(sel);
        invert <= inv;
        repeat (2) @(posedge clk);
        #5;
    endtask : setPads

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin : main
        logic [31:0] d;
        logic [1:0]  r;
        {reset_n, awvalid, wvalid, bready, arvalid, rready, invert} = '0;
        {awaddr, araddr, wdata, wstrb, padSel} = '0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        axiRd(12'h000, d, r);
        chk(d, 32'h0000_0001);
        chk(configWriteLock, 1'b0);
        for (int i = 0; i < 11; i++) begin
            axiWr(selAddr(rows[i][0]), 32'(rows[i][1]), 4'h1, r);
            chk(r, RESP_OKAY);
            axiRd(selAddr(rows[i][0]), d, r);
            chk(d, 64'(rows[i][1]));
            setPads(rows[i][2], 1'b0);
            chk(peripheralInputs, 64'h1 << rows[i][0]);
            @(posedge clk);
            setPads(rows[i][2], 1'b1);
            chk(peripheralInputs, 64'h0);
            @(posedge clk);
            axiWr(selAddr(rows[i][0]), 32'h0, 4'h1, r);
        end
        setPads(31, 1'b1);
        chk(peripheralInputs, 64'h0);
        @(posedge clk);
        axiWr(12'h1BC, 32'h0000_0005, 4'hF, r);
        chk(r, RESP_SLVERR);
        axiRd(12'h1BC, d, r);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        axiWr(12'h000, 32'h0, 4'h1, r);
        axiWr(12'h000, 32'h0000_2000, 4'h2, r);
        chk(configWriteLock, 1'b1);
        axiWr(selAddr(0), 32'h0000_0004, 4'h1, r);
        chk(r, RESP_OKAY);
        axiRd(selAddr(0), d, r);
        chk({r, d}, {RESP_OKAY, 32'h0});
        axiWr(12'h000, 32'h0000_0001, 4'h1, r);
        axiWr(12'h000, 32'h0, 4'h2, r);
        chk(configWriteLock, 1'b1);
        axiWr(12'h000, 32'h0, 4'h1, r);
        axiWr(12'h000, 32'h0, 4'h2, r);
        chk(configWriteLock, 1'b0);
        axiWr(selAddr(0), 32'hFFFF_FFF4, 4'h1, r);
        axiRd(selAddr(0), d, r);
        chk(d, 32'h0000_0004);
        setPads(15, 1'b0);
        chk(peripheralInputs, 64'h1);
        @(posedge clk);
        // a sealed key refuses further key writes until reset
        axiWr(12'h000, 32'h0000_0003, 4'h1, r);
        axiWr(12'h000, 32'h0, 4'h1, r);
        axiRd(12'h000, d, r);
        chk(d, 32'h0000_0003);
        // second reset in mid-run with the pad still high
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(peripheralInputs, 64'h0);
        axiRd(selAddr(0), d, r);
        chk(d, 32'h0);
        axiRd(12'h000, d, r);
        chk(d, 32'h0000_0001);
        giveVerdict();
    end
endmodule : tb_remappable_input_select

`default_nettype wire
